/* hw/mipc_arb.sv */
// Level gate and same-level tie break over the maskable sources
`timescale 1ns/1ps
`include "mipc_defines.svh"
module mipc_arb import mipc_pkg::*;
(
    input  wire logic      [`MIPC_NSRC-1:0]   pend_i,
    input  wire mipc_lvl_t [`MIPC_NSRC-1:0]   lvl_i,
    input  wire logic                         ien_i,
    input  wire mipc_lvl_t                    ipl_i,
    output logic                              hit_o,
    output logic           [`MIPC_SRC_IW-1:0] idx_o,
    output mipc_lvl_t                         lvl_o
);
    // Strict compare keeps the lowest index on a level tie
    always_comb
    begin
        hit_o = 1'b0;
        idx_o = '0;
        lvl_o = `MIPC_LVL_OFF;
        for (int i = 0; i < `MIPC_NSRC; i++)
        begin
            if (ien_i && pend_i[i] && lvl_i[i] > ipl_i &&
                lvl_i[i] > lvl_o) // RULE1 RULE4 RULE5 RULE6 RULE19 RULE23
            begin
                hit_o = 1'b1;
                idx_o = `MIPC_SRC_IW'(i);
                lvl_o = lvl_i[i];
            end
        end
    end
endmodule

/* hw/mipc_ctrl.sv */
// Maskable interrupt acceptance, entry and return sequencer
//
// Functional notes
// (RULE1) Global enable 0 holds off all maskable
// (RULE2) Pending sets on request, clears on accept
// (RULE3) Software only writes 0 to pending
// (RULE4) Level 0 disables source; 7 highest
// (RULE5) Accept: enable, pending, level above processor
// (RULE6) Processor level 7 blocks every maskable
// (RULE7) Enable, pending, levels stored independently
// (RULE8) Arbitrate at instruction end, enter next
// (RULE9) String and MAC instructions get suspended
// (RULE10) Read address zero, then clear pending
// (RULE11) Copy flags, clear enable, step, stack
// (RULE12) Software 32 to 63 keeps stack select
// (RULE13) Push flags, push PC, level, vector
// (RULE14) Critical specials raise level to 7
// (RULE15) Word one: PC top, flags; then PC
// (RULE16) Odd stack pointer saves bytewise
// (RULE17) Save on interrupt stack pointer mostly
// (RULE18) Return restores flags, PC and bank
// (RULE19) Only highest priority request accepted
// (RULE20) Software interrupts ignore all masking
// (RULE21) Non-maskable sources bypass level gating
// (RULE22) Vector at table base plus four times
// (RULE23) Ties go to lowest source number
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "mipc_defines.svh"
module mipc_ctrl import mipc_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_we_i,
    input  wire logic                  reg_re_i,
    output logic      [31:0]           reg_rdata_o,
    input  wire logic [`MIPC_NSRC-1:0] src_req_i,
    input  wire logic                  instr_done_i,
    input  wire logic                  instr_susp_i,
    input  wire logic                  sw_int_i,
    input  wire logic [5:0]            sw_num_i,
    input  wire logic                  spec_req_i,
    input  wire logic                  spec_raise_i,
    input  wire logic [19:0]           spec_vaddr_i,
    input  wire logic                  return_from_irq_instr_i,
    input  wire logic [19:0]           pc_i,
    input  wire logic [15:0]           mem_rdata_i,
    output mipc_mem_t                  mem_o,
    output logic                       pc_load_o,
    output logic      [19:0]           pc_o,
    output logic                       suspend_o,
    output logic                       busy_o
);
    mipc_regs_t                   r_q;
    mipc_regs_t                   r_d;
    logic      [`MIPC_NSRC-1:0]   pend;
    mipc_lvl_t [`MIPC_NSRC-1:0]   lvl;
    logic                         arb_hit;
    logic      [`MIPC_SRC_IW-1:0] arb_idx;
    mipc_lvl_t                    arb_lvl;
    logic                         boundary;
    logic                         sw_go;
    logic                         sp_go;
    logic                         mk_go;
    logic                         go_ret;
    logic                         take;
    logic                         src_wr;
    logic      [`MIPC_SRC_IW-1:0] cidx;
    logic      [15:0]             fword;
    logic      [15:0]             push_w;
    logic      [15:0]             sp_base;
    logic      [15:0]             sp_new;
    logic      [19:0]             vaddr;

    function automatic logic is_src(input logic [7:0] a);
        return a < 8'(`MIPC_NSRC);
    endfunction

    // ------------------------------------------------------------------
    // Source state and arbitration
    // ------------------------------------------------------------------
    assign src_wr = reg_we_i & is_src(reg_addr_i);
    assign cidx   = r_q.acc.num[`MIPC_SRC_IW-1:0];

    mipc_srcctl u_src
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (src_req_i),
        .wr_i      (src_wr),
        .widx_i    (reg_addr_i[`MIPC_SRC_IW-1:0]),
        .wdata_i   (reg_wdata_i[3:0]),
        .clr_i     (r_q.clr),
        .cidx_i    (cidx),
        .pend_o    (pend),
        .lvl_o     (lvl)
    );

    mipc_arb u_arb
    (
        .pend_i (pend),
        .lvl_i  (lvl),
        .ien_i  (r_q.flag_register[`MIPC_FLG_I]),
        .ipl_i  (r_q.flag_register[`MIPC_FLG_IPL]),
        .hit_o  (arb_hit),
        .idx_o  (arb_idx),
        .lvl_o  (arb_lvl)
    );

    // ------------------------------------------------------------------
    // Acceptance and stack words
    // ------------------------------------------------------------------
    assign boundary = instr_done_i | instr_susp_i; // RULE9
    assign sw_go    = sw_int_i & instr_done_i; // RULE20
    assign sp_go    = spec_req_i & boundary; // RULE21
    assign mk_go    = arb_hit & boundary; // RULE8
    assign go_ret   = (r_q.st == ST_IDLE) & return_from_irq_instr_i & instr_done_i;
    assign take     = (r_q.st == ST_IDLE) & ~go_ret &
                      (sw_go | sp_go | mk_go); // RULE19
    assign fword    = {r_q.pcw[19:16], r_q.tmp[15:12],
                       r_q.tmp[7:0]}; // RULE15
    assign push_w   = (r_q.st == ST_PUSHF) ? fword : r_q.pcw[15:0];
    assign sp_base  = r_q.sp - ((r_q.st == ST_PUSHF) ?
                      `MIPC_STK_WORD : `MIPC_STK_FRAME);
    assign sp_new   = (r_q.st == ST_RET3) ? r_q.sp + `MIPC_STK_FRAME
                                          : r_q.sp - `MIPC_STK_FRAME;
    assign vaddr    = r_q.acc.spec ? r_q.acc.svec :
                      r_q.vector_table_base + {12'h000, r_q.acc.num, 2'b00}; // RULE22

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        r_d         = r_q;
        r_d.mem     = '0;
        r_d.clr     = 1'b0;
        r_d.pc_load = 1'b0;
        r_d.suspend = 1'b0;
        r_d.rdata   = '0;
        if (reg_we_i)
        begin
            if (reg_addr_i == `MIPC_A_FLG)
                r_d.flag_register = reg_wdata_i[15:0]; // RULE7
            else if (reg_addr_i == `MIPC_A_VECTOR_TABLE_BASE)
                r_d.vector_table_base = reg_wdata_i[19:0];
            else if (reg_addr_i == `MIPC_A_ISP)
                r_d.irq_stack_pointer = reg_wdata_i[15:0];
            else if (reg_addr_i == `MIPC_A_USP)
                r_d.usp = reg_wdata_i[15:0];
        end
        if (reg_re_i)
        begin
            if (is_src(reg_addr_i))
                r_d.rdata = {28'h000_0000,
                             pend[reg_addr_i[`MIPC_SRC_IW-1:0]],
                             lvl[reg_addr_i[`MIPC_SRC_IW-1:0]]};
            else if (reg_addr_i == `MIPC_A_FLG)
                r_d.rdata = {16'h0000, r_q.flag_register};
            else if (reg_addr_i == `MIPC_A_VECTOR_TABLE_BASE)
                r_d.rdata = {12'h000, r_q.vector_table_base};
            else if (reg_addr_i == `MIPC_A_ISP)
                r_d.rdata = {16'h0000, r_q.irq_stack_pointer};
            else if (reg_addr_i == `MIPC_A_USP)
                r_d.rdata = {16'h0000, r_q.usp};
            else if (reg_addr_i == `MIPC_A_STAT)
                r_d.rdata = {12'h000, r_q.st, r_q.busy,
                             r_q.acc.num, r_q.acc.lvl};
        end
        case (r_q.st)
            ST_IDLE:
            begin
                if (go_ret)
                begin
                    r_d.use_usp = r_q.flag_register[`MIPC_FLG_U];
                    r_d.sp      = r_d.use_usp ? r_q.usp : r_q.irq_stack_pointer;
                    r_d.busy    = 1'b1;
                    r_d.st      = ST_RET1;
                end
                else if (take)
                begin
                    r_d.acc.sw    = sw_go;
                    r_d.acc.spec  = ~sw_go & sp_go;
                    r_d.acc.raise = ~sw_go & sp_go & spec_raise_i;
                    r_d.acc.swu   = sw_go & sw_num_i[`MIPC_SW_USP];
                    r_d.acc.num   = sw_go ? sw_num_i :
                                    (sp_go ? 6'h00 : {3'h0, arb_idx});
                    r_d.acc.lvl   = arb_lvl;
                    r_d.acc.svec  = spec_vaddr_i;
                    r_d.use_usp   = r_d.acc.swu &
                                    r_q.flag_register[`MIPC_FLG_U]; // RULE17
                    r_d.sp        = r_d.use_usp ? r_q.usp : r_q.irq_stack_pointer;
                    r_d.byte_mode = r_d.sp[0]; // RULE16
                    r_d.pcw       = pc_i;
                    r_d.suspend   = instr_susp_i & ~instr_done_i; // RULE9
                    r_d.busy      = 1'b1;
                    r_d.st        = ST_ACK; // RULE8
                end
            end
            ST_ACK:
            begin
                r_d.mem.req  = 1'b1;
                r_d.mem.addr = `MIPC_ACK_ADDR; // RULE10
                r_d.clr      = ~r_q.acc.sw & ~r_q.acc.spec; // RULE2
                r_d.tmp      = r_q.flag_register; // RULE11
                r_d.flag_register[`MIPC_FLG_I] = 1'b0;
                r_d.flag_register[`MIPC_FLG_D] = 1'b0;
                if (!r_q.acc.swu)
                    r_d.flag_register[`MIPC_FLG_U] = 1'b0; // RULE12
                r_d.half     = 1'b0;
                r_d.st       = ST_PUSHF;
            end
            ST_PUSHF, ST_PUSHP:
            begin
                r_d.mem.req     = 1'b1;
                r_d.mem.we      = 1'b1;
                r_d.mem.byte_en = r_q.byte_mode;
                r_d.mem.addr    = {4'h0, sp_base + {15'h0000, r_q.half}};
                if (!r_q.byte_mode)
                    r_d.mem.wdata = push_w; // RULE16
                else if (r_q.half)
                    r_d.mem.wdata = {8'h00, push_w[15:8]};
                else
                    r_d.mem.wdata = {8'h00, push_w[7:0]};
                if (r_q.byte_mode && !r_q.half)
                    r_d.half = 1'b1;
                else if (r_q.st == ST_PUSHF)
                begin
                    r_d.half = 1'b0;
                    r_d.st   = ST_PUSHP; // RULE13
                end
                else
                begin
                    r_d.half = 1'b0;
                    r_d.sp   = sp_new;
                    if (r_q.use_usp)
                        r_d.usp = sp_new;
                    else
                        r_d.irq_stack_pointer = sp_new;
                    r_d.st   = ST_SETL;
                end
            end
            ST_SETL:
            begin
                if (r_q.acc.raise)
                    r_d.flag_register[`MIPC_FLG_IPL] = `MIPC_LVL_TOP; // RULE14
                else if (!r_q.acc.sw && !r_q.acc.spec)
                    r_d.flag_register[`MIPC_FLG_IPL] = r_q.acc.lvl; // RULE13
                r_d.mem.req  = 1'b1;
                r_d.mem.addr = vaddr;
                r_d.st       = ST_VLO;
            end
            ST_VLO:
            begin
                r_d.vlo      = mem_rdata_i;
                r_d.mem.req  = 1'b1;
                r_d.mem.addr = vaddr + `MIPC_VEC_HI;
                r_d.st       = ST_VHI;
            end
            ST_VHI:
            begin
                r_d.pc      = {mem_rdata_i[3:0], r_q.vlo};
                r_d.pc_load = 1'b1;
                r_d.busy    = 1'b0;
                r_d.st      = ST_IDLE;
            end
            ST_RET1:
            begin
                r_d.mem.req  = 1'b1;
                r_d.mem.addr = {4'h0, r_q.sp};
                r_d.st       = ST_RET2;
            end
            ST_RET2:
            begin
                r_d.vlo      = mem_rdata_i;
                r_d.mem.req  = 1'b1;
                r_d.mem.addr = {4'h0, r_q.sp + `MIPC_STK_WORD};
                r_d.st       = ST_RET3;
            end
            ST_RET3:
            begin
                // Bank select sits in the restored flags
                r_d.flag_register     = {mem_rdata_i[11:8], 4'h0,
                               mem_rdata_i[7:0]}; // RULE18
                r_d.pc      = {mem_rdata_i[15:12], r_q.vlo};
                r_d.pc_load = 1'b1;
                r_d.sp      = sp_new;
                if (r_q.use_usp)
                    r_d.usp = sp_new;
                else
                    r_d.irq_stack_pointer = sp_new;
                r_d.busy    = 1'b0;
                r_d.st      = ST_IDLE;
            end
            default:
                r_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            r_q      <= '0;
            r_q.st   <= ST_IDLE;
            r_q.flag_register  <= `MIPC_FLG_RST;
            r_q.vector_table_base <= `MIPC_VECTOR_TABLE_BASE_RST;
            r_q.irq_stack_pointer  <= `MIPC_SP_RST;
            r_q.usp  <= `MIPC_SP_RST;
        end
        else
            r_q <= r_d;
    end

    assign reg_rdata_o = r_q.rdata;
    assign mem_o       = r_q.mem;
    assign pc_load_o   = r_q.pc_load;
    assign pc_o        = r_q.pc;
    assign suspend_o   = r_q.suspend;
    assign busy_o      = r_q.busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_IEN_GATE: // RULE1
    assert property ((r_q.st == ST_ACK && !r_q.acc.sw && !r_q.acc.spec)
        |-> $past(r_q.flag_register[`MIPC_FLG_I]))
        else $error("maskable taken with enable clear");
    AST_LVL_GT: // RULE5
    assert property ((r_q.st == ST_ACK && r_q.clr == 1'b0 && !r_q.acc.sw
        && !r_q.acc.spec) |-> r_q.acc.lvl > $past(r_q.flag_register[`MIPC_FLG_IPL]))
        else $error("level not above processor level");
    AST_PEND_CLR: // RULE2
    assert property ((r_q.clr && !src_req_i[cidx]) |=> !pend[cidx])
        else $error("pending not cleared on accept");
    AST_ACK_READ: // RULE10
    assert property ((r_q.st == ST_ACK) |=> (r_q.mem.req && !r_q.mem.we
        && r_q.mem.addr == `MIPC_ACK_ADDR && r_q.st == ST_PUSHF))
        else $error("entry did not read address zero");
    AST_START_NEXT: // RULE8
    assert property (take |=> r_q.st == ST_ACK && r_q.busy)
        else $error("entry not started next cycle");
    AST_SW_ALWAYS: // RULE20
    assert property ((r_q.st == ST_IDLE && sw_int_i && instr_done_i
        && !return_from_irq_instr_i) |=> (r_q.st == ST_ACK && r_q.acc.sw))
        else $error("software interrupt not taken");
    AST_FLAGS_CLR: // RULE11
    assert property ((r_q.st == ST_ACK) |=> (!r_q.flag_register[`MIPC_FLG_I]
        && !r_q.flag_register[`MIPC_FLG_D] && r_q.tmp == $past(r_q.flag_register)))
        else $error("flags not saved and cleared");
    AST_U_KEEP: // RULE12
    assert property ((r_q.st == ST_ACK) |=> r_q.flag_register[`MIPC_FLG_U] ==
        ($past(r_q.flag_register[`MIPC_FLG_U]) && r_q.acc.swu))
        else $error("stack select handled wrong");
    AST_IPL_SET: // RULE14
    assert property ((r_q.st == ST_SETL && r_q.acc.raise)
        |=> r_q.flag_register[`MIPC_FLG_IPL] == `MIPC_LVL_TOP ##1 r_q.st == ST_VHI)
        else $error("critical special did not raise level");
    AST_BYTE_MODE: // RULE16
    assert property ((r_q.st == ST_PUSHF && r_q.byte_mode && !r_q.half)
        |=> r_q.mem.byte_en ##1 (r_q.mem.byte_en
        && r_q.mem.addr == $past(r_q.mem.addr) + 20'h0_0001))
        else $error("odd pointer save not bytewise");
    AST_RET: // RULE18
    assert property (go_ret |-> ##4 (r_q.pc_load && r_q.st == ST_IDLE))
        else $error("return not finished in four cycles");

    COV_SW: cover property (take && sw_go ##7 r_q.pc_load);
    COV_MASK: cover property (take && mk_go && !sw_go && !sp_go);
    COV_BYTE: cover property (r_q.st == ST_PUSHP && r_q.byte_mode);
    COV_RET: cover property (go_ret ##4 r_q.pc_load);
endmodule

/* hw/mipc_defines.svh */
// Offsets, field positions, reset values and codes of the priority control
`ifndef MIPC_DEFINES_SVH
`define MIPC_DEFINES_SVH

// ----------------------------------------------------------------------
// Sources and levels
// ----------------------------------------------------------------------
`define MIPC_NSRC       8
`define MIPC_SRC_IW     3
`define MIPC_LVL_OFF    3'h0
`define MIPC_LVL_TOP    3'h7
`define MIPC_SC_PEND    3

// ----------------------------------------------------------------------
// Flag register layout
// ----------------------------------------------------------------------
`define MIPC_FLG_D      1
`define MIPC_FLG_I      6
`define MIPC_FLG_U      7
`define MIPC_FLG_IPL    14:12
`define MIPC_FLG_RST    16'h0000

// ----------------------------------------------------------------------
// Entry and return sequence
// ----------------------------------------------------------------------
`define MIPC_ACK_ADDR   20'h0_0000
`define MIPC_SW_USP     5
`define MIPC_STK_WORD   16'h0002
`define MIPC_STK_FRAME  16'h0004
`define MIPC_VEC_HI     20'h0_0002
`define MIPC_VECTOR_TABLE_BASE_RST   20'h0_0000
`define MIPC_SP_RST     16'h0000

// ----------------------------------------------------------------------
// Register port map
// ----------------------------------------------------------------------
`define MIPC_A_FLG      8'h10
`define MIPC_A_VECTOR_TABLE_BASE     8'h11
`define MIPC_A_ISP      8'h12
`define MIPC_A_USP      8'h13
`define MIPC_A_STAT     8'h14

`endif

/* hw/mipc_pkg.sv */
// Types of the maskable interrupt priority control
package mipc_pkg;
    `include "mipc_defines.svh"

    typedef logic [2:0] mipc_lvl_t;

    typedef enum logic [9:0]
    {
        ST_IDLE  = 10'h001,
        ST_ACK   = 10'h002,
        ST_PUSHF = 10'h004,
        ST_PUSHP = 10'h008,
        ST_SETL  = 10'h010,
        ST_VLO   = 10'h020,
        ST_VHI   = 10'h040,
        ST_RET1  = 10'h080,
        ST_RET2  = 10'h100,
        ST_RET3  = 10'h200
    } mipc_state_t;

    typedef struct packed
    {
        logic        req;
        logic        we;
        logic        byte_en;
        logic [19:0] addr;
        logic [15:0] wdata;
    } mipc_mem_t;

    typedef struct packed
    {
        logic        sw;
        logic        spec;
        logic        raise;
        logic        swu;
        logic [5:0]  num;
        mipc_lvl_t   lvl;
        logic [19:0] svec;
    } mipc_acc_t;

    typedef struct packed
    {
        mipc_state_t st;
        logic [15:0] flag_register;
        logic [15:0] tmp;
        logic [19:0] vector_table_base;
        logic [15:0] irq_stack_pointer;
        logic [15:0] usp;
        logic [15:0] sp;
        logic        use_usp;
        logic        byte_mode;
        logic        half;
        mipc_acc_t   acc;
        logic [19:0] pcw;
        logic [15:0] vlo;
        mipc_mem_t   mem;
        logic        clr;
        logic        pc_load;
        logic [19:0] pc;
        logic        suspend;
        logic        busy;
        logic [31:0] rdata;
    } mipc_regs_t;

    typedef struct packed
    {
        logic      [`MIPC_NSRC-1:0] pend;
        mipc_lvl_t [`MIPC_NSRC-1:0] lvl;
    } mipc_src_t;
endpackage

/* hw/mipc_srcctl.sv */
// Per-source pending bits and request levels
`timescale 1ns/1ps
`include "mipc_defines.svh"
module mipc_srcctl import mipc_pkg::*;
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [`MIPC_NSRC-1:0]    set_i,
    input  wire logic                     wr_i,
    input  wire logic [`MIPC_SRC_IW-1:0]  widx_i,
    input  wire logic [3:0]               wdata_i,
    input  wire logic                     clr_i,
    input  wire logic [`MIPC_SRC_IW-1:0]  cidx_i,
    output logic      [`MIPC_NSRC-1:0]    pend_o,
    output mipc_lvl_t [`MIPC_NSRC-1:0]    lvl_o
);
    mipc_src_t s_q;
    mipc_src_t s_d;

    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < `MIPC_NSRC; i++)
        begin
            if (wr_i && widx_i == `MIPC_SRC_IW'(i))
            begin
                s_d.lvl[i]  = wdata_i[2:0]; // RULE7
                s_d.pend[i] = s_q.pend[i] & wdata_i[`MIPC_SC_PEND]; // RULE3
            end
            if (clr_i && cidx_i == `MIPC_SRC_IW'(i))
                s_d.pend[i] = 1'b0; // RULE10
            if (set_i[i])
                s_d.pend[i] = 1'b1; // RULE2
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign pend_o = s_q.pend;
    assign lvl_o  = s_q.lvl;
endmodule

/* tb/mipc_mem_model.sv */
// Memory model answering the sequencer's stack and vector accesses
`timescale 1ns/1ps
module mipc_mem_model import mipc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire mipc_mem_t   mem_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] m [0:511];

    // Each even address holds its own value
    initial
    begin
        for (int i = 0; i < 512; i++)
            m[i] = 16'(2 * i);
    end

    // Read answers in the request cycle; idle shows the inverse
    always_comb
    begin
        rdata_o = ~m[mem_i.addr[9:1]];
        if (mem_i.req && !mem_i.we)
            rdata_o = m[mem_i.addr[9:1]];
    end

    always @(posedge ref_clk_i)
    begin
        if (mem_i.req && mem_i.we && !mem_i.byte_en)
            m[mem_i.addr[9:1]] <= mem_i.wdata;
        if (mem_i.req && mem_i.we && mem_i.byte_en && mem_i.addr[0])
            m[mem_i.addr[9:1]][15:8] <= mem_i.wdata[7:0];
        if (mem_i.req && mem_i.we && mem_i.byte_en && !mem_i.addr[0])
            m[mem_i.addr[9:1]][7:0] <= mem_i.wdata[7:0];
    end
endmodule

/* tb/mipc_tb_top.sv */
// Self-checking bench of the maskable interrupt sequencer
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) \
        begin \
            err_count++; \
            $display("BAD %0t got %h want %h", $time, a, b); \
        end \
    end
module mipc_tb_top import mipc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  src_req = 8'h00;
    logic        instr_done = 1'b0;
    logic        instr_susp = 1'b0;
    logic        sw_int = 1'b0;
    logic [5:0]  sw_num = 6'h00;
    logic        spec_req = 1'b0;
    logic        spec_raise = 1'b1;
    logic        return_from_irq_instr = 1'b0;
    logic [15:0] mem_rdata;
    mipc_mem_t   mem;
    logic        pc_load;
    logic [19:0] pc_o;
    logic        suspend;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    bit          susp_seen;

    mipc_ctrl u_mipc_ctrl (.ref_clk_i(ref_clk), .rst_i(rst),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
        .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .src_req_i(src_req),
        .instr_done_i(instr_done), .instr_susp_i(instr_susp),
        .sw_int_i(sw_int), .sw_num_i(sw_num), .spec_req_i(spec_req),
        .spec_raise_i(spec_raise), .spec_vaddr_i(20'h0_0300), .return_from_irq_instr_i(return_from_irq_instr),
        .pc_i(20'h1_2345), .mem_rdata_i(mem_rdata), .mem_o(mem),
        .pc_load_o(pc_load), .pc_o(pc_o), .suspend_o(suspend),
        .busy_o());
    mipc_mem_model u_mipc_mem_model (.ref_clk_i(ref_clk), .mem_i(mem),
        .rdata_o(mem_rdata));

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        @(posedge ref_clk);
        `CHK(reg_rdata, e)
    endtask

    task automatic pulse(input logic [7:0] m);
        src_req <= m;
        @(posedge ref_clk);
        src_req <= 8'h00;
    endtask

    // Ends one instruction, or suspends it when s is set, then watches 12 cycles for a new program counter
    task automatic take(input bit hit, input logic [19:0] e, input bit s);
        bit got;
        got = 0;
        susp_seen = 0;
        instr_done <= !s;
        instr_susp <= s;
        repeat (12)
        begin
            @(posedge ref_clk);
            susp_seen |= suspend === 1'b1;
            if (pc_load === 1'b1)
            begin
                got = 1;
                `CHK(pc_o, e)
            end
            instr_done <= 1'b0;
            instr_susp <= 1'b0;
            sw_int <= 1'b0;
            return_from_irq_instr <= 1'b0;
            spec_req <= 1'b0;
        end
        `CHK(got, hit)
    endtask

    function automatic logic [19:0] vpc(input logic [19:0] v);
        vpc = {v[3:0] + 4'h2, v[15:0]};
    endfunction

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(8'h14, 32'h0000_0400);
        rd(8'h1F, 32'h0000_0000);
        wr(8'h11, 32'h0000_0100);
        wr(8'h12, 32'h0000_0200);
        wr(8'h10, 32'h0000_0040);
        wr(8'h03, 32'h0000_0005);
        pulse(8'h08);
        rd(8'h03, 32'h0000_000D);
        wr(8'h03, 32'h0000_0005);
        rd(8'h03, 32'h0000_0005);
        pulse(8'h08);
        take(1, vpc(20'h0_010C), 1);
        `CHK(susp_seen, 1'b1)
        rd(8'h10, 32'h0000_5000);
        rd(8'h12, 32'h0000_01FC);
        rd(8'h03, 32'h0000_0005);
        `CHK(u_mipc_mem_model.m[255], 16'h1040)
        `CHK(u_mipc_mem_model.m[254], 16'h2345)
        $display("test entry done");
        wr(8'h10, 32'h0000_5040);
        wr(8'h01, 32'h0000_0005);
        wr(8'h02, 32'h0000_0006);
        wr(8'h06, 32'h0000_0006);
        pulse(8'h46);
        take(1, vpc(20'h0_0108), 0);
        rd(8'h06, 32'h0000_000E);
        rd(8'h10, 32'h0000_6000);
        return_from_irq_instr <= 1'b1;
        take(1, 20'h1_2345, 0);
        rd(8'h10, 32'h0000_5040);
        rd(8'h12, 32'h0000_01FC);
        $display("test arbitration done");
        wr(8'h10, 32'h0000_0000);
        take(0, 20'h0_0000, 0);
        wr(8'h10, 32'h0000_7040);
        take(0, 20'h0_0000, 0);
        wr(8'h10, 32'h0000_5040);
        take(1, vpc(20'h0_0118), 0);
        rd(8'h01, 32'h0000_000D);
        sw_int <= 1'b1;
        sw_num <= 6'd40;
        take(1, vpc(20'h0_01A0), 0);
        rd(8'h10, 32'h0000_6000);
        $display("test masking done");
        wr(8'h12, 32'h0000_0201);
        spec_req <= 1'b1;
        take(1, 20'h2_0300, 0);
        rd(8'h10, 32'h0000_7000);
        rd(8'h12, 32'h0000_01FD);
        `CHK(u_mipc_mem_model.m[255], 16'h0023)
        `CHK(u_mipc_mem_model.m[256][7:0], 8'h16)
        `CHK(u_mipc_mem_model.m[254][15:8], 8'h45)
        wr(8'h10, 32'h0000_2000);
        spec_raise <= 1'b0;
        spec_req <= 1'b1;
        take(1, 20'h2_0300, 0);
        rd(8'h10, 32'h0000_2000);
        wr(8'h10, 32'h0000_0080);
        wr(8'h13, 32'h0000_0180);
        sw_int <= 1'b1;
        take(1, vpc(20'h0_01A0), 0);
        rd(8'h13, 32'h0000_017C);
        rd(8'h10, 32'h0000_0080);
        $display("test special done");
        print_verdict();
    end
endmodule
